// *** lbp_ctrl.sv ***
// led buck protection and timing controller
`timescale 1ns/1ps
`include "lbp_defs.svh"

module lbp_ctrl
    import lbp_pkg::*;
#(
    parameter int SC_DET_CYC = `LBP_SC_DET_CYC,
    parameter int NTC_TO_CYC = `LBP_NTC_TO_CYC
) (
    // clock and reset
    input  wire logic        MCLK,
    input  wire logic        RST_B,
    // analog comparators and thermistor level code
    input  wire lbp_cmp_t    CMP_IN,
    input  wire logic [7:0]  THERM_CODE,
    // register port
    input  wire logic [3:0]  REG_ADDR,
    input  wire logic [31:0] REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic      [31:0] REG_RDATA,
    // power stage and supply
    output logic             GATE,
    output logic             BACKUP_REG_EN,
    output logic             HV_START_REQ,
    output logic             LED_HOT_FLAG,
    output logic      [7:0]  PEAK_SET
);
    localparam int NCMP = $bits(lbp_cmp_t);

    function automatic logic [1:0] reg_sel(input logic [3:0] a);
        case (a)
            `LBP_ADDR_CTRL:   reg_sel = 2'h0;
            `LBP_ADDR_STATUS: reg_sel = 2'h1;
            `LBP_ADDR_PEAK:   reg_sel = 2'h2;
            default:          reg_sel = 2'h3;
        endcase
    endfunction : reg_sel

    logic [NCMP-1:0]       sync1_q;
    logic [NCMP-1:0]       sync2_q;
    lbp_cmp_t              c;
    logic                  run_q;
    logic                  die_off_q;
    logic                  short_latch_q;
    logic                  enable_q;
    logic                  tm_early_q;
    lbp_sw_t               sw_q;
    lbp_sw_t               sw_d;
    logic [`LBP_PH_W-1:0]  ph_cnt_q;
    lbp_ntc_t              nt_q;
    logic [`LBP_NT_W-1:0]  nt_cnt_q;
    logic                  sc_run_q;
    logic [`LBP_SC_W-1:0]  sc_cnt_q;
    logic                  inhibit;
    logic                  ton_max_hit;
    logic                  toff_max_hit;
    logic                  on_end;
    logic                  sc_expire;
    logic                  nt_expire;
    logic                  dimmed;
    logic                  led_hot;
    lbp_status_t           status;

    // synchroniser: stage one feeds only stage two
    genvar gi;
    generate
        for (gi = 0; gi < NCMP; gi++) begin : g_sync
            always_ff @(posedge MCLK or negedge RST_B) begin
                if (!RST_B) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= CMP_IN[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate
    assign c = lbp_cmp_t'(sync2_q);

    assign dimmed  = (nt_q == NT_DIMMED);
    assign led_hot = (nt_q == NT_LEDHOT);
    assign inhibit = !run_q || die_off_q || short_latch_q || led_hot || dimmed
                     || !enable_q;

    // supply lockout with hysteresis
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            run_q <= 1'b0;
        end else if (c.vcc_below_stop) begin
            run_q <= 1'b0;
        end else if (c.vcc_above_start) begin
            run_q <= 1'b1;
        end
    end

    // die overtemperature
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            die_off_q <= 1'b0;
        end else if (c.die_hot) begin
            die_off_q <= 1'b1;
        end else if (c.die_cool) begin
            die_off_q <= 1'b0;
        end
    end

    // switching sequence
    assign ton_max_hit  = (sw_q == SW_ON)
                          && (ph_cnt_q == `LBP_PH_W'(`LBP_TON_MAX_CYC - 1));
    assign toff_max_hit = (sw_q == SW_OFF)
                          && (ph_cnt_q == `LBP_PH_W'(`LBP_TOFF_MAX_CYC - 1));
    // a floating pin trips before the minimum, a grounded one never does
    assign on_end = ton_max_hit
        || (c.peak_trip && ph_cnt_q >= `LBP_PH_W'(`LBP_LEB_CYC))
        || (c.on_time_modulation_input_trip && !tm_early_q && ph_cnt_q >= `LBP_PH_W'(`LBP_TON_MIN_CYC));

    // a floating pin stays tripped, so an early trip masks the rest of the phase
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            tm_early_q <= 1'b0;
        end else if (sw_q != SW_ON) begin
            tm_early_q <= 1'b0;
        end else if (c.on_time_modulation_input_trip && ph_cnt_q < `LBP_PH_W'(`LBP_TON_MIN_CYC)) begin
            tm_early_q <= 1'b1;
        end
    end

    always_comb begin
        sw_d = sw_q;
        case (sw_q)
            SW_IDLE: begin
                sw_d = SW_ON;
            end
            SW_ON: begin
                if (on_end) begin
                    sw_d = SW_OFF;
                end
            end
            SW_OFF: begin
                if (c.valley_ok || toff_max_hit) begin
                    sw_d = SW_ON;
                end
            end
            default: begin
                sw_d = SW_IDLE;
            end
        endcase
        if (inhibit) begin
            sw_d = SW_IDLE;
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            sw_q     <= SW_IDLE;
            ph_cnt_q <= '0;
            GATE     <= 1'b0;
        end else begin
            sw_q     <= sw_d;
            GATE     <= (sw_d == SW_ON);
            ph_cnt_q <= (sw_d != sw_q) ? '0 : ph_cnt_q + 1'b1;
        end
    end

    // short-circuit detection timer
    assign sc_expire = sc_run_q && (sc_cnt_q == `LBP_SC_W'(SC_DET_CYC - 1));

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            sc_run_q <= 1'b0;
            sc_cnt_q <= '0;
        end else if (dimmed) begin
            sc_run_q <= sc_run_q;
        end else if (c.vcc_below_stop || ton_max_hit
                     || (sw_q == SW_OFF && c.valley_ok)) begin
            sc_run_q <= 1'b0;
            sc_cnt_q <= '0;
        end else if (sc_expire) begin
            sc_run_q <= 1'b0;
            sc_cnt_q <= '0;
        end else if (sc_run_q) begin
            sc_cnt_q <= sc_cnt_q + 1'b1;
        end else if (toff_max_hit) begin
            sc_run_q <= 1'b1;
            sc_cnt_q <= '0;
        end
    end

    // latched short protection, released only by a deep supply dip
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            short_latch_q <= 1'b0;
        end else if (c.vcc_below_rst) begin
            short_latch_q <= 1'b0;
        end else if (sc_expire && !dimmed && !c.vcc_below_stop && !ton_max_hit
                     && !(sw_q == SW_OFF && c.valley_ok)) begin
            short_latch_q <= 1'b1;
        end
    end

    // thermistor discrimination
    assign nt_expire = (nt_cnt_q == `LBP_NT_W'(NTC_TO_CYC - 1));

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            nt_q     <= NT_NORMAL;
            nt_cnt_q <= '0;
        end else begin
            nt_cnt_q <= '0;
            case (nt_q)
                NT_NORMAL: begin
                    if (c.ntc_below_act) begin
                        nt_q <= NT_TIMING;
                    end
                end
                NT_TIMING: begin
                    nt_cnt_q <= nt_cnt_q + 1'b1;
                    if (c.ntc_below_deact) begin
                        nt_q <= NT_DIMMED;
                    end else if (nt_expire) begin
                        nt_q <= NT_LEDHOT;
                    end else if (!c.ntc_below_act) begin
                        nt_q <= NT_NORMAL;
                    end
                end
                NT_DIMMED: begin
                    if (THERM_CODE > `LBP_THERM_LOW) begin
                        nt_q <= NT_NORMAL;
                    end
                end
                NT_LEDHOT: begin
                    if (THERM_CODE > `LBP_THERM_HIGH) begin
                        nt_q <= NT_NORMAL;
                    end
                end
                default: begin
                    nt_q <= NT_NORMAL;
                end
            endcase
        end
    end

    // derating: code span equals half the nominal setting
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            PEAK_SET <= `LBP_PEAK_HALF;
        end else if (THERM_CODE >= `LBP_THERM_HIGH) begin
            PEAK_SET <= `LBP_PEAK_NOM;
        end else if (THERM_CODE <= `LBP_THERM_LOW) begin
            PEAK_SET <= `LBP_PEAK_HALF;
        end else begin
            PEAK_SET <= `LBP_PEAK_HALF + (THERM_CODE - `LBP_THERM_LOW);
        end
    end

    // supply side outputs; hv restart covers lockout and hot shutdowns
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            BACKUP_REG_EN <= 1'b0;
            HV_START_REQ  <= 1'b1;
            LED_HOT_FLAG  <= 1'b0;
        end else begin
            BACKUP_REG_EN <= c.vcc_below_regon;
            HV_START_REQ  <= !run_q || die_off_q || led_hot;
            LED_HOT_FLAG  <= led_hot;
        end
    end

    // register port
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            enable_q <= `LBP_CTRL_RESET;
        end else if (REG_WR && reg_sel(REG_ADDR) == 2'h0
                     && REG_ADDR == `LBP_ADDR_CTRL) begin
            enable_q <= REG_WDATA[`LBP_CTRL_EN_BIT];
        end
    end

    assign status = '{sw_state: sw_q, sc_running: sc_run_q, gate: GATE,
                      backup_reg: BACKUP_REG_EN, dimmed: dimmed, led_hot: led_hot,
                      short_latch: short_latch_q, die_off: die_off_q, run: run_q};

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            REG_RDATA <= 32'h0;
        end else if (REG_RD) begin
            case (reg_sel(REG_ADDR))
                2'h0:    REG_RDATA <= {31'h0, enable_q};
                2'h1:    REG_RDATA <= {22'h0, status};
                2'h2:    REG_RDATA <= {24'h0, PEAK_SET};
                default: REG_RDATA <= (REG_ADDR == `LBP_ADDR_SCCNT)
                                      ? {14'h0, sc_cnt_q} : 32'h0;
            endcase
        end else begin
            REG_RDATA <= 32'h0;
        end
    end

    // checks
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_B);

    property p_ton_limit;
        (sw_q == SW_ON) |-> (ph_cnt_q < `LBP_PH_W'(`LBP_TON_MAX_CYC));
    endproperty
    a_ton_limit: assert property (p_ton_limit)
        else $error("on-phase ran past maximum on-time");

    property p_die_off;
        die_off_q |=> !GATE;
    endproperty
    a_die_off: assert property (p_die_off)
        else $error("switching while die hot");

    property p_latch_off;
        short_latch_q |=> !GATE;
    endproperty
    a_latch_off: assert property (p_latch_off)
        else $error("switching while short latched");

    property p_latch_hold;
        short_latch_q && !c.vcc_below_rst |=> short_latch_q;
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("short latch released above reset level");

    property p_lockout;
        !run_q |=> !GATE;
    endproperty
    a_lockout: assert property (p_lockout)
        else $error("switching in lockout");

    property p_backup;
        ##1 (BACKUP_REG_EN == $past(c.vcc_below_regon));
    endproperty
    a_backup: assert property (p_backup)
        else $error("backup regulator does not follow supply level");

    property p_sc_freeze;
        dimmed |=> (sc_cnt_q == $past(sc_cnt_q)) && (sc_run_q == $past(sc_run_q));
    endproperty
    a_sc_freeze: assert property (p_sc_freeze)
        else $error("short timer moved during dimming");

    property p_sc_latch;
        sc_expire && !dimmed && !c.vcc_below_stop && !c.vcc_below_rst
            && !ton_max_hit && !(sw_q == SW_OFF && c.valley_ok) |=> short_latch_q;
    endproperty
    a_sc_latch: assert property (p_sc_latch)
        else $error("short timer expiry did not latch");

    property p_blank;
        (sw_q == SW_ON) && (ph_cnt_q < `LBP_PH_W'(`LBP_LEB_CYC)) && !inhibit
            |=> (sw_q == SW_ON);
    endproperty
    a_blank: assert property (p_blank)
        else $error("on-phase ended inside blanking");

    property p_led_hot;
        (nt_q == NT_TIMING) && nt_expire && !c.ntc_below_deact |=> led_hot ##1 LED_HOT_FLAG;
    endproperty
    a_led_hot: assert property (p_led_hot)
        else $error("thermistor timeout did not flag led hot");

endmodule : lbp_ctrl

// *** lbp_defs.svh ***
// constants for the led buck protection controller
`ifndef LBP_DEFS_SVH
`define LBP_DEFS_SVH

`define LBP_CLK_MHZ        25
`define LBP_TON_MAX_NS     15000
`define LBP_TON_MIN_NS     1000
`define LBP_LEB_NS         300
`define LBP_TOFF_MAX_NS    50000
`define LBP_TON_MAX_CYC    ((`LBP_TON_MAX_NS * `LBP_CLK_MHZ) / 1000)
`define LBP_TON_MIN_CYC    ((`LBP_TON_MIN_NS * `LBP_CLK_MHZ + 999) / 1000)
`define LBP_LEB_CYC        ((`LBP_LEB_NS * `LBP_CLK_MHZ + 999) / 1000)
`define LBP_TOFF_MAX_CYC   ((`LBP_TOFF_MAX_NS * `LBP_CLK_MHZ) / 1000)
`define LBP_SC_DET_US      10000
`define LBP_NTC_TO_US      1000
`define LBP_SC_DET_CYC     (`LBP_SC_DET_US * `LBP_CLK_MHZ)
`define LBP_NTC_TO_CYC     (`LBP_NTC_TO_US * `LBP_CLK_MHZ)
`define LBP_PH_W           11
`define LBP_SC_W           18
`define LBP_NT_W           18

`define LBP_THERM_LOW      8'h40
`define LBP_THERM_HIGH     8'hBF
`define LBP_PEAK_NOM       8'hFF
`define LBP_PEAK_HALF      8'h80

`define LBP_ADDR_CTRL      4'h0
`define LBP_ADDR_STATUS    4'h4
`define LBP_ADDR_PEAK      4'h8
`define LBP_ADDR_SCCNT     4'hC
`define LBP_CTRL_RESET     1'h1
`define LBP_CTRL_EN_BIT    0

`endif

// *** lbp_pkg.sv ***
// types shared by the led buck protection controller
package lbp_pkg;
    typedef struct packed {
        logic vcc_above_start;
        logic vcc_below_stop;
        logic vcc_below_rst;
        logic vcc_below_regon;
        logic die_hot;
        logic die_cool;
        logic peak_trip;
        logic valley_ok;
        logic on_time_modulation_input_trip;
        logic ntc_below_act;
        logic ntc_below_deact;
    } lbp_cmp_t;

    typedef enum logic [1:0] {
        SW_IDLE = 2'h0,
        SW_ON   = 2'h1,
        SW_OFF  = 2'h3
    } lbp_sw_t;

    typedef enum logic [1:0] {
        NT_NORMAL = 2'h0,
        NT_TIMING = 2'h1,
        NT_DIMMED = 2'h3,
        NT_LEDHOT = 2'h2
    } lbp_ntc_t;

    typedef struct packed {
        lbp_sw_t sw_state;
        logic    sc_running;
        logic    gate;
        logic    backup_reg;
        logic    dimmed;
        logic    led_hot;
        logic    short_latch;
        logic    die_off;
        logic    run;
    } lbp_status_t;
endpackage : lbp_pkg

// *** lbp_stage_model.sv ***
// power stage and comparator model for the protection controller
`timescale 1ns/1ps
module lbp_stage_model (
    // clock and switch drive
    input  wire logic        mclk,
    input  wire logic        gate,
    // stage timing from the bench, zero means never
    input  wire logic [15:0] pk_cyc,
    input  wire logic [15:0] vl_cyc,
    input  wire logic [15:0] tm_cyc,
    // comparator levels
    output logic             peak_trip,
    output logic             valley_ok,
    output logic             on_time_modulation_input_trip
);
    logic g_q = 1'b0;
    int   n   = 0;

    // phase counter restarts on every gate change, like the coil current
    always @(posedge mclk) begin
        g_q         <= gate;
        n           <= (gate != g_q) ? 1 : n + 1;
        peak_trip   <= gate && pk_cyc != 0 && n >= pk_cyc;
        valley_ok   <= !gate && vl_cyc != 0 && n >= vl_cyc;
        on_time_modulation_input_trip <= gate && tm_cyc != 0 && n >= tm_cyc;
    end
endmodule : lbp_stage_model

// *** tb_led_buck_protection_control.sv ***
// self-checking bench for the led buck protection controller
`timescale 1ns/1ps
module tb_led_buck_protection_control;
    import lbp_pkg::*;
    logic        mclk = 1'b0;
    logic        rst_b;
    lbp_cmp_t    sup;
    lbp_cmp_t    cmp;
    logic [7:0]  therm;
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic        gate;
    logic        bkp;
    logic        hvreq;
    logic        hot;
    logic [7:0]  peak;
    logic [15:0] pk;
    logic [15:0] vl;
    logic [15:0] tm;
    logic        pk_trip;
    logic        vly;
    logic        tmt;
    int          n_fail = 0;
    int          checks_done = 0;
    int          cyc = 0;

    always #20 mclk = ~mclk;

    always_comb begin
        cmp             = sup;
        cmp.peak_trip   = pk_trip;
        cmp.valley_ok   = vly;
        cmp.on_time_modulation_input_trip = tmt;
    end

    // short counts keep the run brief
    lbp_ctrl #(.SC_DET_CYC(500), .NTC_TO_CYC(20)) lbp_ctrl_inst (
        .MCLK(mclk), .RST_B(rst_b), .CMP_IN(cmp), .THERM_CODE(therm),
        .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
        .REG_RDATA(rdata), .GATE(gate), .BACKUP_REG_EN(bkp),
        .HV_START_REQ(hvreq), .LED_HOT_FLAG(hot), .PEAK_SET(peak)
    );

    lbp_stage_model lbp_stage_model_inst (
        .mclk(mclk), .gate(gate), .pk_cyc(pk), .vl_cyc(vl), .tm_cyc(tm),
        .peak_trip(pk_trip), .valley_ok(vly), .on_time_modulation_input_trip(tmt)
    );

    task automatic report_and_stop;
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr    <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd   <= 1'b0;
        @(negedge mclk);
        d = rdata;
    endtask : reg_rd

    task automatic stat(input int b, input logic e);
        logic [31:0] d;
        reg_rd(4'h4, d);
        chk({31'h0, d[b]}, {31'h0, e});
    endtask : stat

    // samples on falling edges so gate never races its own update
    task automatic wait_gate(input logic v, input int lim, output int k);
        k = 0;
        do begin
            @(negedge mclk);
            k++;
        end while (gate !== v && k < lim);
    endtask : wait_gate

    task automatic pulse(output int w);
        int k;
        wait_gate(1'b1, 3000, k);
        wait_gate(1'b0, 3000, w);
    endtask : pulse

    task automatic t_start;
        int k;
        logic [31:0] d;
        @(negedge mclk);
        chk(gate, 0);
        chk(peak, 32'h80);
        reg_rd(4'h0, d);
        chk(d, 1);
        reg_rd(4'h2, d);
        chk(d, 0);
        wait_gate(1'b1, 50, k);
        chk(k, 50);
        @(posedge mclk);
        sup.vcc_above_start <= 1'b1;
        sup.ntc_below_act   <= 1'b0;
        sup.ntc_below_deact <= 1'b0;
        therm               <= 8'hFF;
        wait_gate(1'b1, 50, k);
        chk(k < 50, 1);
        chk(peak, 32'hFF);
        $display("start test done");
    endtask : t_start

    task automatic t_on;
        int w;
        logic [31:0] d;
        @(posedge mclk);
        pk <= 16'd1;
        pulse(w);
        pulse(w);
        chk(w >= 8 && w <= 14, 1);
        @(posedge mclk);
        pk <= 16'd100;
        pulse(w);
        pulse(w);
        chk(w >= 100 && w <= 106, 1);
        @(posedge mclk);
        pk <= 16'd0;
        tm <= 16'd60;
        pulse(w);
        pulse(w);
        chk(w >= 60 && w <= 68, 1);
        @(posedge mclk);
        tm <= 16'd1;
        pulse(w);
        pulse(w);
        chk(w >= 373 && w <= 377, 1);
        @(posedge mclk);
        tm <= 16'd0;
        vl <= 16'd0;
        pulse(w);
        pulse(w);
        pulse(w);
        chk(w >= 373 && w <= 377, 1);
        stat(2, 0);
        reg_rd(4'hC, d);
        chk(d, 32'h0);
        $display("on-time test done");
    endtask : t_on

    task automatic t_short;
        int k;
        @(posedge mclk);
        pk <= 16'd20;
        tick(3000);
        stat(2, 1);
        wait_gate(1'b1, 200, k);
        chk(k, 200);
        @(posedge mclk);
        sup.vcc_below_stop <= 1'b1;
        tick(5);
        sup.vcc_below_stop <= 1'b0;
        tick(5);
        stat(2, 1);
        @(posedge mclk);
        sup.vcc_below_stop  <= 1'b1;
        sup.vcc_below_rst   <= 1'b1;
        sup.vcc_above_start <= 1'b0;
        tick(5);
        stat(2, 0);
        @(posedge mclk);
        sup.vcc_below_stop <= 1'b0;
        sup.vcc_below_rst  <= 1'b0;
        vl                 <= 16'd10;
        wait_gate(1'b1, 100, k);
        chk(k, 100);
        @(posedge mclk);
        sup.vcc_above_start <= 1'b1;
        wait_gate(1'b1, 100, k);
        chk(k < 100, 1);
        @(posedge mclk);
        sup.vcc_above_start <= 1'b0;
        tick(50);
        wait_gate(1'b1, 100, k);
        chk(k < 100, 1);
        $display("short test done");
    endtask : t_short

    task automatic t_die;
        int k;
        @(posedge mclk);
        sup.die_hot <= 1'b1;
        tick(5);
        stat(1, 1);
        wait_gate(1'b1, 100, k);
        chk(k, 100);
        @(posedge mclk);
        sup.die_hot <= 1'b0;
        wait_gate(1'b1, 100, k);
        chk(k, 100);
        @(posedge mclk);
        sup.die_cool <= 1'b1;
        wait_gate(1'b1, 100, k);
        chk(k < 100, 1);
        $display("die test done");
    endtask : t_die

    task automatic t_reg;
        int k;
        logic [31:0] d;
        reg_wr(4'h0, 32'h0);
        reg_rd(4'h0, d);
        chk(d, 0);
        wait_gate(1'b1, 100, k);
        chk(k, 100);
        reg_wr(4'h0, 32'h1);
        wait_gate(1'b1, 100, k);
        chk(k < 100, 1);
        reg_rd(4'h8, d);
        chk(d, 32'hFF);
        @(posedge mclk);
        sup.vcc_below_regon <= 1'b1;
        tick(4);
        @(negedge mclk);
        chk(bkp, 1);
        @(posedge mclk);
        sup.vcc_below_regon <= 1'b0;
        tick(4);
        @(negedge mclk);
        chk(bkp, 0);
        $display("register test done");
    endtask : t_reg

    task automatic t_peak;
        logic [7:0] code [7] = '{8'hFF, 8'hBF, 8'hBE, 8'h80, 8'h41, 8'h40, 8'h00};
        logic [7:0] exp  [7] = '{8'hFF, 8'hFF, 8'hFE, 8'hC0, 8'h81, 8'h80, 8'h80};
        for (int i = 0; i < 7; i++) begin
            @(posedge mclk);
            therm <= code[i];
            tick(2);
            @(negedge mclk);
            chk(peak, exp[i]);
        end
        @(posedge mclk);
        therm <= 8'hFF;
        $display("peak test done");
    endtask : t_peak

    task automatic t_dim;
        int k;
        @(posedge mclk);
        sup.ntc_below_act <= 1'b1;
        therm             <= 8'h00;
        tick(5);
        sup.ntc_below_deact <= 1'b1;
        tick(5);
        stat(4, 1);
        chk(hot, 0);
        chk(hvreq, 0);
        wait_gate(1'b1, 100, k);
        chk(k, 100);
        @(posedge mclk);
        sup.ntc_below_act   <= 1'b0;
        sup.ntc_below_deact <= 1'b0;
        therm               <= 8'h30;
        wait_gate(1'b1, 100, k);
        chk(k, 100);
        @(posedge mclk);
        therm <= 8'h41;
        wait_gate(1'b1, 100, k);
        chk(k < 100, 1);
        $display("dimming test done");
    endtask : t_dim

    task automatic t_hot;
        int k;
        @(posedge mclk);
        therm             <= 8'h20;
        sup.ntc_below_act <= 1'b1;
        tick(40);
        @(negedge mclk);
        chk(hot, 1);
        chk(hvreq, 1);
        wait_gate(1'b1, 100, k);
        chk(k, 100);
        @(posedge mclk);
        sup.ntc_below_act <= 1'b0;
        therm             <= 8'h80;
        wait_gate(1'b1, 100, k);
        chk(k, 100);
        @(posedge mclk);
        therm <= 8'hC0;
        wait_gate(1'b1, 100, k);
        chk(k < 100, 1);
        chk(hot, 0);
        $display("led hot test done");
    endtask : t_hot

    // hang guard, well above the expected run length
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_fail++;
            report_and_stop();
        end
    end

    initial begin
        sup                 = '0;
        sup.ntc_below_act   = 1'b1;
        sup.ntc_below_deact = 1'b1;
        therm = 8'h00;
        addr  = 4'h0;
        wdata = 32'h0;
        wr    = 1'b0;
        rd    = 1'b0;
        pk    = 16'd20;
        vl    = 16'd10;
        tm    = 16'd0;
        rst_b = 1'b0;
        repeat (6) @(posedge mclk);
        rst_b <= 1'b1;
        t_start();
        t_on();
        t_short();
        t_die();
        t_reg();
        t_peak();
        t_dim();
        t_hot();
        report_and_stop();
    end
endmodule : tb_led_buck_protection_control
